// ### dv/dswd_board.sv
`default_nettype none
module dswd_board (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // Board lines
  input  wire logic [4:0] i_ev,
  output logic      [7:0] o_cnt [5]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] ev_q;
  // ****************************************
  // Rising edge counters
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ev_q <= 5'h00;
      for (int k = 0; k < 5; k++) o_cnt[k] <= 8'h00;
    end else begin
      ev_q <= i_ev;
      for (int k = 0; k < 5; k++) if (i_ev[k] && !ev_q[k]) o_cnt[k] <= o_cnt[k] + 8'h01;
    end
  end
endmodule // dswd_board
`default_nettype wire

// ### dv/dswd_checker.sv
`default_nettype none
module dswd_top_checker (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  // APB
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Actions
  input wire logic        o_reset_req,
  input wire logic        o_nmi,
  input wire logic        o_system_management_interrupt,
  input wire logic        o_system_control_interrupt,
  input wire logic        o_timeout_output_pin,
  input wire logic        o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // ****************************************
  // Assertions
  // ****************************************
  a_pin_sticky: assert property (o_timeout_output_pin |=> o_timeout_output_pin)
    else $error("timeout pin dropped");
  a_pin_clear: assert property ($rose(i_arst_n) |-> !o_timeout_output_pin)
    else $error("timeout pin high after reset");
  a_reset_width: assert property ($rose(o_reset_req) |-> ##15 o_reset_req ##1 !o_reset_req)
    else $error("reset request width");
  a_nmi_width: assert property ($rose(o_nmi) |-> o_nmi[*8] ##8 o_nmi ##1 !o_nmi)
    else $error("nmi width");
  a_mgmt_width: assert property ($rose(o_system_management_interrupt) |->
    ##15 o_system_management_interrupt ##1 !o_system_management_interrupt)
    else $error("management interrupt width");
  a_ctrl_width: assert property ($rose(o_system_control_interrupt) |->
    o_system_control_interrupt[*8] ##8 o_system_control_interrupt ##1 !o_system_control_interrupt)
    else $error("control interrupt width");
  a_one_action: assert property ($onehot0({$rose(o_reset_req), $rose(o_nmi),
    $rose(o_system_management_interrupt), $rose(o_system_control_interrupt)}))
    else $error("two actions at once");
  a_ready_high: assert property (o_pready)
    else $error("pready low");
  a_err_range: assert property (i_psel && i_penable && (i_paddr > 12'h01C || i_paddr[1:0] != 2'h0) |-> o_pslverr)
    else $error("no error on bad address");
  a_err_data: assert property (o_pslverr |-> o_prdata == 32'h0)
    else $error("data on refused read");
  c_reset: cover property ($rose(o_reset_req));
  c_ctrl: cover property ($rose(o_system_control_interrupt));
  c_irq: cover property ($rose(o_irq));
endmodule // dswd_top_checker
`default_nettype wire

// ### dv/dswd_tb.sv
`default_nettype none
`include "dswd_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk, i_arst_n, i_psel, i_penable, i_pwrite, er;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, o_reset_req, o_nmi, o_irq;
  logic        o_system_management_interrupt, o_system_control_interrupt, o_timeout_output_pin;
  logic [7:0]  cnt [5];
  int          error_cnt, checks;
  dswd_top dut (.i_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .o_reset_req, .o_nmi, .o_system_management_interrupt,
    .o_system_control_interrupt, .o_timeout_output_pin, .o_irq);
  dswd_board board (.i_clk, .i_arst_n, .o_cnt(cnt), .i_ev({o_timeout_output_pin,
    o_system_control_interrupt, o_system_management_interrupt, o_nmi, o_reset_req}));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      finish_test();
    end
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task automatic wait_cnt(input int k, input logic [7:0] n);
    int i;
    for (i = 0; i < 45000; i++) begin
      @(posedge i_clk);
      if (cnt[k] >= n) break;
    end
    if (i == 45000) begin
      error_cnt++;
      finish_test();
    end
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    i_arst_n = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h0;
    i_pwdata = 32'h0;
    error_cnt = 0;
    checks = 0;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rdm(`DSWD_OFF_ID, 32'hFFFFFFFF, `DSWD_ID_VALUE, "id");
    rdm(`DSWD_OFF_STATUS, 32'hF, 32'h1, "status idle");
    rdm(`DSWD_OFF_IRQ_MSK, 32'hFFFFFFFF, 32'h0, "mask");
    rdm(12'h020, 32'hFFFFFFFF, 32'h0, "unmapped data");
    chk("unmapped err", 32'h1, {31'h0, er});
    xfer(1'b1, `DSWD_OFF_IRQ_MSK, 32'h1C);
    xfer(1'b1, `DSWD_OFF_STAGE1, 32'h9);
    xfer(1'b1, `DSWD_OFF_STAGE2, 32'h3);
    xfer(1'b1, `DSWD_OFF_CTRL, 32'h1);
    xfer(1'b1, `DSWD_OFF_SERVICE, `DSWD_SERVICE_KEY);
    rdm(`DSWD_OFF_STATUS, 32'h7, 32'h2, "fsm stage one");
    wait_cnt(0, 8'h01);
    chk("pin", 32'h1, {31'h0, o_timeout_output_pin});
    wait_cnt(2, 8'h01);
    rdm(`DSWD_OFF_IRQ_ST, 32'h1C, 32'h1C, "irq status");
    chk("irq", 32'h1, {31'h0, o_irq});
    xfer(1'b1, `DSWD_OFF_IRQ_ST, 32'h1C);
    repeat (2) @(posedge i_clk);
    chk("irq clear", 32'h0, {31'h0, o_irq});
    xfer(1'b1, `DSWD_OFF_STAGE1, 32'hA);
    xfer(1'b1, `DSWD_OFF_STAGE2, 32'h5);
    xfer(1'b1, `DSWD_OFF_SERVICE, `DSWD_SERVICE_KEY);
    wait_cnt(1, 8'h01);
    xfer(1'b1, `DSWD_OFF_STAGE1, 32'h4);
    wait_cnt(3, 8'h01);
    chk("resets", 32'h1, {24'h0, cnt[0]});
    chk("mgmt irqs", 32'h1, {24'h0, cnt[2]});
    chk("pin held", 32'h1, {31'h0, o_timeout_output_pin});
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("pin reset", 32'h0, {31'h0, o_timeout_output_pin});
    i_arst_n <= 1'b1;
    finish_test();
  end
endmodule // testbench
bind dswd_top dswd_top_checker u_chk (.i_clk, .i_arst_n, .i_psel, .i_penable, .i_paddr, .o_prdata,
  .o_pready, .o_pslverr, .o_reset_req, .o_nmi, .o_system_management_interrupt,
  .o_system_control_interrupt, .o_timeout_output_pin, .o_irq);
`default_nettype wire

// ### shared/dswd_defs.svh
`ifndef DSWD_DEFS_SVH
`define DSWD_DEFS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define DSWD_OFF_CTRL    12'h000
`define DSWD_OFF_STAGE1  12'h004
`define DSWD_OFF_STAGE2  12'h008
`define DSWD_OFF_SERVICE 12'h00C
`define DSWD_OFF_STATUS  12'h010
`define DSWD_OFF_IRQ_ST  12'h014
`define DSWD_OFF_IRQ_MSK 12'h018
`define DSWD_OFF_ID      12'h01C
// ****************************************
// Fields
// ****************************************
`define DSWD_CTRL_EN_BIT     0
`define DSWD_CTRL_PINSEL_BIT 1
`define DSWD_ACT_LSB         0
`define DSWD_ACT_W           4
`define DSWD_TIME_LSB        8
`define DSWD_TIME_W          24
`define DSWD_PIN_FLAG_BIT    3
`define DSWD_SERVICE_KEY     32'h0000_5A5A
// ****************************************
// Action codes
// ****************************************
`define DSWD_ACT_OFF     3'h0
`define DSWD_ACT_RESET   3'h1
`define DSWD_ACT_NMI     3'h2
`define DSWD_ACT_SYS_MGMT 3'h3
`define DSWD_ACT_SYS_CTRL 3'h4
`define DSWD_ACT_DELAY   3'h5
`define DSWD_ACT_PINONLY 4'h8
// ****************************************
// Reset values and timing
// ****************************************
`define DSWD_RST_CTRL    2'h0
`define DSWD_RST_STAGE   28'h0000000
`define DSWD_RST_MASK    5'h00
// Identity value is arbitrary
`define DSWD_ID_VALUE    32'h0000_00A5
`define DSWD_CLK_HZ      20000000
`define DSWD_TICK_US     1000
`define DSWD_TICK_CYC    ((`DSWD_CLK_HZ / 1000000) * `DSWD_TICK_US)
`define DSWD_PULSE_CYC   16
`endif

// ### shared/dswd_pkg.sv
`default_nettype none
package dswd_pkg;
  typedef struct packed {
    logic [23:0] timeout;
    logic [3:0]  action;
  } dswd_stage_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dswd_apb_req_t;

  typedef struct packed {
    logic        rst_req;
    logic        nmi;
    logic        sys_mgmt;
    logic        sys_ctrl;
  } dswd_act_t;

  typedef enum logic [2:0] {
    DSWD_IDLE   = 3'b001,
    DSWD_STAGE1 = 3'b010,
    DSWD_STAGE2 = 3'b100
  } dswd_state_t;
endpackage
`default_nettype wire

// ### verilog/dswd_tick.sv
`default_nettype none
`include "dswd_defs.svh"
module dswd_tick
  import dswd_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Control
  input  wire logic i_clear,
  output logic      o_tick
);
  localparam int unsigned TICK_CYC = `DSWD_TICK_CYC;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } dswd_tick_st_t;

  dswd_tick_st_t st_q;
  dswd_tick_st_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (i_clear) begin
      st_d.cnt = 16'h0000;
    end else if (st_q.cnt == 16'(TICK_CYC - 1)) begin
      st_d.cnt  = 16'h0000;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;
endmodule // dswd_tick
`default_nettype wire

// ### verilog/dswd_top.sv
// Implementation choices: the APB register port and the register addresses.
`default_nettype none
`include "dswd_defs.svh"
// Contract
// - Two independently set stages run one after the other.
// - Action code 0000b switches a stage off so it is skipped with no action.
// - Code 0001b on expiry requests a full module reset.
// - Code 0010b on expiry raises a non-maskable interrupt.
// - Code 0011b on expiry raises a system-management interrupt.
// - Code 0100b on expiry raises a system-control interrupt.
// - Code 0101b is a pure delay, accepted only in the first stage.
// - Code 1000b on expiry drives only the timeout output pin.
// - Codes 1001b to 1101b act as their bit-3-clear twin and also drive the pin.
// - The pin rises when the watchdog was not serviced within the driving stage's time.
// - Software ties the pin to either the first or the second stage.
// - The pin clears only on reset.
module dswd_top
  import dswd_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Timeout actions
  output logic             o_reset_req,
  output logic             o_nmi,
  output logic             o_system_management_interrupt,
  output logic             o_system_control_interrupt,
  output logic             o_timeout_output_pin,
  // Interrupt
  output logic             o_irq
);
  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic        enable;
    logic        pin_sel;
    dswd_stage_t stage1;
    dswd_stage_t stage2;
    dswd_state_t fsm;
    logic [23:0] count;
    logic        pin;
    logic [4:0]  irq_st;
    logic [4:0]  irq_msk;
    dswd_act_t   act;
    logic [4:0]  pulse_cnt;
    logic [31:0] prdata;
    logic        expired1;
    logic        expired2;
  } dswd_st_t;

  dswd_st_t    st_q;
  dswd_st_t    st_d;
  dswd_apb_req_t apb;
  logic        tick;
  logic        wr;
  logic        rd;
  logic        service;
  logic        clear_tick;

  assign apb = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite, paddr: i_paddr, pwdata: i_pwdata};
  assign wr  = apb.psel && apb.penable && apb.pwrite;
  assign rd  = apb.psel && !apb.penable && !apb.pwrite;
  assign service = wr && (apb.paddr == `DSWD_OFF_SERVICE) && (apb.pwdata == `DSWD_SERVICE_KEY);
  assign clear_tick = service || !st_q.enable;

  dswd_tick u_tick (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_clear (clear_tick),
    .o_tick  (tick)
  );

  // ****************************************
  // Action decode
  // ****************************************
  function automatic logic stage_on(input logic [3:0] code, input logic first);
    logic [2:0] base;
    logic       ok;
    base = code[2:0];
    ok   = 1'b0;
    if (code == `DSWD_ACT_PINONLY) begin
      ok = 1'b1;
    end else if (base >= `DSWD_ACT_RESET && base <= `DSWD_ACT_SYS_CTRL) begin
      ok = 1'b1;
    end else if (base == `DSWD_ACT_DELAY) begin
      ok = first;
    end
    return ok;
  endfunction

  function automatic dswd_act_t stage_act(input logic [3:0] code);
    dswd_act_t a;
    a = '0;
    if (code != `DSWD_ACT_PINONLY) begin
      unique case (code[2:0])
        `DSWD_ACT_RESET: a.rst_req = 1'b1;
        `DSWD_ACT_NMI:   a.nmi     = 1'b1;
        `DSWD_ACT_SYS_MGMT: a.sys_mgmt = 1'b1;
        `DSWD_ACT_SYS_CTRL: a.sys_ctrl = 1'b1;
        default:         a         = '0;
      endcase
    end
    return a;
  endfunction

  function automatic logic stage_pin(input logic [3:0] code, input logic first);
    return stage_on(code, first) && code[`DSWD_PIN_FLAG_BIT];
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic       s1_on;
  logic       s2_on;
  logic [4:0] ev;

  assign s1_on = stage_on(st_q.stage1.action, 1'b1);
  assign s2_on = stage_on(st_q.stage2.action, 1'b0);

  always_comb begin
    st_d          = st_q;
    st_d.expired1 = 1'b0;
    st_d.expired2 = 1'b0;
    ev            = 5'h00;
    // Action pulse stretch
    if (st_q.pulse_cnt != 5'h00) begin
      st_d.pulse_cnt = st_q.pulse_cnt - 5'h01;
    end else begin
      st_d.act = '0;
    end

    // Timer sequence
    if (!st_q.enable) begin
      st_d.fsm   = DSWD_IDLE;
      st_d.count = 24'h000000;
    end else if (service) begin
      st_d.fsm   = s1_on ? DSWD_STAGE1 : (s2_on ? DSWD_STAGE2 : DSWD_IDLE);
      st_d.count = 24'h000000;
    end else begin
      unique case (st_q.fsm)
        DSWD_IDLE: begin
          st_d.fsm   = s1_on ? DSWD_STAGE1 : (s2_on ? DSWD_STAGE2 : DSWD_IDLE);
          st_d.count = 24'h000000;
        end
        DSWD_STAGE1: begin
          if (tick) begin
            if (st_q.count + 24'h000001 >= st_q.stage1.timeout) begin
              st_d.expired1 = 1'b1;
              st_d.act      = stage_act(st_q.stage1.action);
              st_d.pulse_cnt = 5'(`DSWD_PULSE_CYC - 1);
              st_d.count    = 24'h000000;
              st_d.fsm      = s2_on ? DSWD_STAGE2 : DSWD_IDLE;
              if (stage_pin(st_q.stage1.action, 1'b1) && !st_q.pin_sel) begin
                st_d.pin = 1'b1;
              end
            end else begin
              st_d.count = st_q.count + 24'h000001;
            end
          end
        end
        DSWD_STAGE2: begin
          if (tick) begin
            if (st_q.count + 24'h000001 >= st_q.stage2.timeout) begin
              st_d.expired2 = 1'b1;
              st_d.act      = stage_act(st_q.stage2.action);
              st_d.pulse_cnt = 5'(`DSWD_PULSE_CYC - 1);
              st_d.count    = 24'h000000;
              st_d.fsm      = DSWD_IDLE;
              if (stage_pin(st_q.stage2.action, 1'b0) && st_q.pin_sel) begin
                st_d.pin = 1'b1;
              end
            end else begin
              st_d.count = st_q.count + 24'h000001;
            end
          end
        end
        default: begin
          st_d.fsm = DSWD_IDLE;
        end
      endcase
    end
    // Idle after second stage, or after the first with the second off, holds for two cycles, then the sequence restarts without a service
    if (st_q.fsm == DSWD_IDLE && st_q.enable && !service && (st_q.expired2 || (st_q.expired1 && !s2_on))) begin
      st_d.fsm = DSWD_IDLE;
    end

    // Register writes
    if (wr) begin
      unique case (apb.paddr)
        `DSWD_OFF_CTRL: begin
          st_d.enable  = apb.pwdata[`DSWD_CTRL_EN_BIT];
          st_d.pin_sel = apb.pwdata[`DSWD_CTRL_PINSEL_BIT];
        end
        `DSWD_OFF_STAGE1: begin
          st_d.stage1.action  = apb.pwdata[`DSWD_ACT_LSB +: `DSWD_ACT_W];
          st_d.stage1.timeout = apb.pwdata[`DSWD_TIME_LSB +: `DSWD_TIME_W];
        end
        `DSWD_OFF_STAGE2: begin
          st_d.stage2.action  = apb.pwdata[`DSWD_ACT_LSB +: `DSWD_ACT_W];
          st_d.stage2.timeout = apb.pwdata[`DSWD_TIME_LSB +: `DSWD_TIME_W];
        end
        `DSWD_OFF_IRQ_ST:  st_d.irq_st  = st_q.irq_st & ~apb.pwdata[4:0];
        `DSWD_OFF_IRQ_MSK: st_d.irq_msk = apb.pwdata[4:0];
        default: ;
      endcase
    end

    // Sticky events, set wins over clear
    ev = {st_d.pin && !st_q.pin, st_q.expired2, st_q.expired1, 1'b0, service};
    st_d.irq_st = st_d.irq_st | ev;

    // Read data
    st_d.prdata = 32'h0000_0000;
    if (rd) begin
      unique case (apb.paddr)
        `DSWD_OFF_CTRL:    st_d.prdata = {30'h0, st_q.pin_sel, st_q.enable};
        `DSWD_OFF_STAGE1:  st_d.prdata = {st_q.stage1.timeout, 4'h0, st_q.stage1.action};
        `DSWD_OFF_STAGE2:  st_d.prdata = {st_q.stage2.timeout, 4'h0, st_q.stage2.action};
        `DSWD_OFF_STATUS:  st_d.prdata = {st_q.count, 4'h0, st_q.pin, st_q.fsm};
        `DSWD_OFF_IRQ_ST:  st_d.prdata = {27'h0, st_q.irq_st};
        `DSWD_OFF_IRQ_MSK: st_d.prdata = {27'h0, st_q.irq_msk};
        `DSWD_OFF_ID:      st_d.prdata = `DSWD_ID_VALUE;
        default:           st_d.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= '0;
      st_q.fsm     <= DSWD_IDLE;
      st_q.pin     <= 1'b0;
      st_q.irq_msk <= `DSWD_RST_MASK;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic addr_ok;
  assign addr_ok = (apb.paddr[1:0] == 2'b00) && (apb.paddr <= `DSWD_OFF_ID);

  assign o_prdata  = st_q.prdata;
  assign o_pready  = 1'b1;
  assign o_pslverr = apb.psel && apb.penable && !addr_ok;
  assign o_reset_req                   = st_q.act.rst_req;
  assign o_nmi                         = st_q.act.nmi;
  assign o_system_management_interrupt = st_q.act.sys_mgmt;
  assign o_system_control_interrupt    = st_q.act.sys_ctrl;
  assign o_timeout_output_pin          = st_q.pin;
  assign o_irq = |(st_q.irq_st & st_q.irq_msk);
endmodule // dswd_top
`default_nettype wire
